// file: design/ccm_params.svh
// Constants for the CPU clock mode selection block.
// Assumes inclusion by the package and the block; definitions only.
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH
`define CCM_STRAP_X4       3'h7
`define CCM_STRAP_X3       3'h6
`define CCM_STRAP_X8       3'h5
`define CCM_STRAP_X5       3'h4
`define CCM_STRAP_DIRECT   3'h3
`define CCM_STRAP_X10      3'h2
`define CCM_STRAP_PRESCALE 3'h1
`define CCM_STRAP_X16      3'h0
`define CCM_FACTOR_X1      5'h01
`define CCM_FACTOR_X3      5'h03
`define CCM_FACTOR_X4      5'h04
`define CCM_FACTOR_X5      5'h05
`define CCM_FACTOR_X8      5'h08
`define CCM_FACTOR_X10     5'h0A
`define CCM_FACTOR_X16     5'h10
`define CCM_WDOG_DIS_BIT   4
`define CCM_WDOG_DIS_RESET 1'h0
`define CCM_WDOG_LIMIT     5'h10
`define CCM_STRAP_RESET    3'h7
`endif

// file: design/ccm_pkg.sv
// Types for the CPU clock mode selection block.
// Assumes the constants header sits beside it.
`include "ccm_params.svh"
package ccm_pkg;
  typedef enum logic [1:0] {
    CCM_MODE_PLL       = 2'h0,
    CCM_MODE_DIRECT    = 2'h1,
    CCM_MODE_PRESCALE  = 2'h2
  } ccm_mode_type;

  typedef enum logic [1:0] {
    CCM_SRC_PLL        = 2'h0,
    CCM_SRC_CRYSTAL    = 2'h1,
    CCM_SRC_CRYSTAL_DIV = 2'h2
  } ccm_src_type;

  typedef struct packed {
    ccm_mode_type mode;
    ccm_src_type  source;
    logic [4:0]   pll_factor;
    logic         pll_enable;
    logic         pll_free_run;
    logic         wdog_active;
  } ccm_status_type;
endpackage

// file: design/ccm_clock_mode.sv
// CPU clock mode selection: latches the straps at reset release, decodes the
// clock generation mode, runs the prescaler phase and the oscillator watchdog.
// Assumes sys_clk_i is the system clock; crystal_input_i is a sampled level.
`timescale 1ns/1ns
`include "ccm_params.svh"
module ccm_clock_mode (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Straps and configuration
  input  wire logic [2:0]           clock_mode_straps_i,
  input  wire logic [7:0]           system_config_register_i,
  // Oscillator activity
  input  wire logic                 crystal_input_i,
  input  wire logic                 pll_clk_tick_i,
  // Status and clock outputs
  output ccm_pkg::ccm_status_type   status_o,
  output logic                      cpu_clk_phase_o,
  output logic                      clock_half_period_o,
  output logic                      external_clock_allowed_o,
  output logic                      osc_watchdog_irq_o
);
  import ccm_pkg::*;

  // ==========================================================
  // Strap capture
  // The first clocked edge after release catches the straps; the async
  // reset can only load a constant, so a capture flag marks that edge.
  logic [2:0]     strap_reg;
  logic [2:0]     strap_next;
  logic           captured_reg;
  logic           captured_next;

  always_comb begin
    strap_next    = strap_reg;
    captured_next = 1'b1;
    if (!captured_reg) begin
      strap_next = clock_mode_straps_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_reg    <= `CCM_STRAP_RESET;
      captured_reg <= 1'b0;
    end else begin
      strap_reg    <= strap_next;
      captured_reg <= captured_next;
    end
  end

  // ==========================================================
  // Mode decode
  ccm_mode_type mode;
  logic [4:0]   factor;

  always_comb begin
    case (strap_reg)
      `CCM_STRAP_X4: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X4;
      end
      `CCM_STRAP_X3: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X3;
      end
      `CCM_STRAP_X8: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X8;
      end
      `CCM_STRAP_X5: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X5;
      end
      `CCM_STRAP_DIRECT: begin
        mode   = CCM_MODE_DIRECT;
        factor = `CCM_FACTOR_X1;
      end
      `CCM_STRAP_X10: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X10;
      end
      `CCM_STRAP_PRESCALE: begin
        mode   = CCM_MODE_PRESCALE;
        factor = `CCM_FACTOR_X1;
      end
      `CCM_STRAP_X16: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X16;
      end
      // Three strap bits leave no other code; this keeps the decode latch free.
      default: begin
        mode   = CCM_MODE_PLL;
        factor = `CCM_FACTOR_X4;
      end
    endcase
  end

  // The disable bit is a level from the configuration byte; it is not latched,
  // so software may switch the watchdog at any time, not only at reset.
  logic wdog_disable;
  logic wdog_enable;
  assign wdog_disable = system_config_register_i[`CCM_WDOG_DIS_BIT];
  assign wdog_enable  = (mode != CCM_MODE_PLL) && !wdog_disable;

  // ==========================================================
  // Prescaler phase and oscillator watchdog
  // One phase per input clock period: the phase toggles on every rising
  // edge of the sampled crystal level, so high and low last one period.
  logic       xtal_prev_reg;
  logic       xtal_prev_next;
  logic       phase_reg;
  logic       phase_next;
  logic       half_reg;
  logic       half_next;
  logic [4:0] wdog_cnt_reg;
  logic [4:0] wdog_cnt_next;
  logic       failed_reg;
  logic       failed_next;
  logic       irq_reg;
  logic       irq_next;
  logic       xtal_rise;
  logic       xtal_edge;

  // The previous level is only known after the first edge out of reset, so no
  // edge is reported before it; otherwise a crystal sitting high fakes a rise.
  assign xtal_edge = (crystal_input_i ^ xtal_prev_reg) & captured_reg;
  assign xtal_rise = crystal_input_i & ~xtal_prev_reg & captured_reg;

  always_comb begin
    xtal_prev_next = crystal_input_i;
    phase_next     = phase_reg;
    half_next      = 1'b0;
    wdog_cnt_next  = wdog_cnt_reg;
    failed_next    = failed_reg;
    irq_next       = 1'b0;
    if (mode == CCM_MODE_PRESCALE) begin
      if (xtal_rise) begin
        phase_next = ~phase_reg;
        half_next  = 1'b1;
      end
    end else if (xtal_edge) begin
      half_next = 1'b1;
    end
    // Once switched to the pll, only a reset brings the crystal back.
    // A crystal edge in the same cycle as a tick wins, so a live crystal trips
    // the watchdog only if 16 pll ticks fall between two of its edges.
    if (wdog_enable && !failed_reg) begin
      if (xtal_edge) begin
        wdog_cnt_next = 5'h00;
      end else if (pll_clk_tick_i) begin
        if (wdog_cnt_reg == `CCM_WDOG_LIMIT - 5'h01) begin
          failed_next = 1'b1;
          irq_next    = 1'b1;
        end else begin
          wdog_cnt_next = wdog_cnt_reg + 5'h01;
        end
      end
    end else begin
      wdog_cnt_next = 5'h00;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_prev_reg <= 1'b0;
      phase_reg     <= 1'b0;
      half_reg      <= 1'b0;
      wdog_cnt_reg  <= 5'h00;
      failed_reg    <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      xtal_prev_reg <= xtal_prev_next;
      phase_reg     <= phase_next;
      half_reg      <= half_next;
      wdog_cnt_reg  <= wdog_cnt_next;
      failed_reg    <= failed_next;
      irq_reg       <= irq_next;
    end
  end

  // ==========================================================
  // Outputs
  ccm_src_type src;
  always_comb begin
    case (mode)
      CCM_MODE_DIRECT:   src = failed_reg ? CCM_SRC_PLL : CCM_SRC_CRYSTAL;
      CCM_MODE_PRESCALE: src = failed_reg ? CCM_SRC_PLL : CCM_SRC_CRYSTAL_DIV;
      default:           src = CCM_SRC_PLL;
    endcase
  end

  // Pll modes always run from the pll; the other modes fall back to it only
  // after a watchdog failure, and stay there until the next reset.
  always_comb begin
    status_o.mode         = mode;
    status_o.source       = src;
    status_o.pll_factor   = factor;
    status_o.pll_enable   = (mode == CCM_MODE_PLL) || wdog_enable;
    status_o.pll_free_run = wdog_enable;
    status_o.wdog_active  = wdog_enable && !failed_reg;
  end

  assign cpu_clk_phase_o          = phase_reg;
  assign clock_half_period_o      = half_reg;
  assign external_clock_allowed_o = (mode == CCM_MODE_DIRECT);
  assign osc_watchdog_irq_o       = irq_reg;
endmodule

// file: test/ccm_monitor.sv
// Checker for the clock mode block, bound to its ports.
// Assumes one clock domain with asynchronous reset rst_i.
`timescale 1ns/1ns
module ccm_monitor import ccm_pkg::*; (
  input wire logic           sys_clk_i,
  input wire logic           rst_i,
  input wire logic [7:0]     system_config_register_i,
  input wire logic           crystal_input_i,
  input wire ccm_status_type status_o,
  input wire logic           cpu_clk_phase_o,
  input wire logic           external_clock_allowed_o,
  input wire logic           osc_watchdog_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire nonpll = status_o.mode != CCM_MODE_PLL;
  wire wdog_off = system_config_register_i[4];
  ext_only_a: assert property (
    external_clock_allowed_o == (status_o.mode == CCM_MODE_DIRECT)) else $error("ext flag");
  pll_on_a: assert property (!nonpll |-> status_o.pll_enable) else $error("pll off");
  wdog_run_a: assert property (
    nonpll && !wdog_off |-> status_o.pll_free_run) else $error("no free run");
  wdog_off_a: assert property (
    nonpll && wdog_off |-> !status_o.pll_enable) else $error("pll left on");
  mode_hold_a: assert property (
    !$past(rst_i) && !$past(rst_i, 2) |-> $stable(status_o.mode)) else $error("mode moved");
  phase_edge_a: assert property (
    $changed(cpu_clk_phase_o) |-> $past(crystal_input_i) && !$past(crystal_input_i, 2))
    else $error("phase without crystal rise");
  irq_pulse_a: assert property (
    osc_watchdog_irq_o |=> !osc_watchdog_irq_o) else $error("irq too long");
  irq_source_a: assert property (
    osc_watchdog_irq_o |-> status_o.source == CCM_SRC_PLL) else $error("irq, no switch");
  irq_pll_a: assert property (!nonpll |-> !osc_watchdog_irq_o) else $error("irq in pll");
  source_hold_a: assert property (
    $past(status_o.source) == CCM_SRC_PLL && $past(nonpll) && nonpll
    |-> status_o.source == CCM_SRC_PLL) else $error("switched back");
endmodule
bind ccm_clock_mode ccm_monitor mon_u (.sys_clk_i, .rst_i, .system_config_register_i,
  .crystal_input_i, .status_o, .cpu_clk_phase_o, .external_clock_allowed_o,
  .osc_watchdog_irq_o);

// file: test/ccm_osc_model.sv
// Crystal and pll free-running tick source for the clock mode block.
// Assumes the bench clock; run_i low models a failed crystal.
`timescale 1ns/1ns
module ccm_osc_model #(parameter int HALF = 3) (
  input  wire logic sys_clk_i,
  input  wire logic run_i,
  output logic      crystal_input_o,
  output logic      pll_tick_o
);
  int cnt = 0;
  logic go;
  initial begin
    crystal_input_o = 1'h0;
    pll_tick_o      = 1'h0;
  end
  // A failed crystal freezes at its last level, the hardest case to spot.
  // Run is taken at the edge, so a bench change in the same step cannot race it.
  always @(posedge sys_clk_i) begin
    go = run_i;
    #5;
    pll_tick_o = 1'h1;
    if (go) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) crystal_input_o = ~crystal_input_o;
    end
  end
endmodule

// file: test/ccm_clock_mode_test.sv
// Self-checking bench for the clock mode block.
// Assumes the oscillator model and the bound checker.
`timescale 1ns/1ns
module ccm_clock_mode_test;
  import ccm_pkg::*;
  typedef struct packed {logic [2:0] s; ccm_mode_type m; logic [4:0] f;} ccm_row_type;
  logic sys_clk_i = 0, rst_i = 1, run = 1, xtal, tick, phase, half, ext, irq, px, pp;
  logic [2:0] straps = 3'h7;
  logic [7:0] cfg = 8'h00;
  ccm_status_type st;
  int err_count = 0, n_checks = 0, cyc = 0, edges, tog, hp, irqs, flips;
  ccm_row_type rows [8] = '{'{3'h7, CCM_MODE_PLL, 5'h04}, '{3'h6, CCM_MODE_PLL, 5'h03},
    '{3'h5, CCM_MODE_PLL, 5'h08}, '{3'h4, CCM_MODE_PLL, 5'h05}, '{3'h3, CCM_MODE_DIRECT, 5'h01},
    '{3'h2, CCM_MODE_PLL, 5'h0A}, '{3'h1, CCM_MODE_PRESCALE, 5'h00}, '{3'h0, CCM_MODE_PLL, 5'h10}};
  ccm_osc_model osc_u (.sys_clk_i, .run_i(run), .crystal_input_o(xtal), .pll_tick_o(tick));
  ccm_clock_mode dut_u (.sys_clk_i, .rst_i, .clock_mode_straps_i(straps),
    .system_config_register_i(cfg), .crystal_input_i(xtal), .pll_clk_tick_i(tick),
    .status_o(st), .cpu_clk_phase_o(phase), .clock_half_period_o(half),
    .external_clock_allowed_o(ext), .osc_watchdog_irq_o(irq));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Straps are flipped after capture so a design that keeps sampling them shows it.
  task boot(input logic [2:0] s, input logic [7:0] c);
    @(posedge sys_clk_i);
    #5 rst_i = 1;
    straps = s;
    cfg = c;
    run = 1;
    repeat (2) @(posedge sys_clk_i);
    #5 rst_i = 0;
    @(posedge sys_clk_i);
    #5 straps = ~s;
    repeat (2) @(posedge sys_clk_i);
    #5;
  endtask
  task watch(input int n);
    edges = 0; tog = 0; hp = 0; irqs = 0; flips = 0;
    @(posedge sys_clk_i);
    #1 px = xtal;
    pp = phase;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1 edges += (xtal === 1'h1 && px === 1'h0);
      tog += (phase !== pp);
      flips += (xtal !== px);
      hp += (half === 1'h1);
      irqs += (irq === 1'h1);
      px = xtal;
      pp = phase;
    end
    #4;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      boot(rows[i].s, 8'h00);
      chk("mode", rows[i].m, st.mode);
      chk("ext", {7'h00, rows[i].m == CCM_MODE_DIRECT}, ext);
      if (rows[i].f != 5'h00) chk("factor", rows[i].f, st.pll_factor);
    end
    boot(3'h1, 8'h00);
    watch(60);
    chk("free_run", 1, st.pll_free_run);
    chk("wdog_on", 1, st.wdog_active);
    chk("toggles", edges, tog);
    chk("half_pulses", edges, hp);
    run = 0;
    watch(24);
    chk("irq", 1, irqs);
    chk("failsrc", CCM_SRC_PLL, st.source);
    chk("wdog_done", 0, st.wdog_active);
    run = 1;
    watch(20);
    chk("held", CCM_SRC_PLL, st.source);
    boot(3'h3, 8'h10);
    chk("pll_off", 0, st.pll_enable);
    chk("wdog_off", 0, st.wdog_active);
    watch(30);
    chk("dir_half", flips, hp);
    chk("dir_phase", 0, tog);
    run = 0;
    watch(24);
    chk("no_irq", 0, irqs);
    boot(3'h7, 8'h00);
    run = 0;
    watch(24);
    chk("pll_irq", 0, irqs);
    boot(3'h3, 8'h00);
    chk("direct", CCM_SRC_CRYSTAL, st.source);
    run = 0;
    watch(24);
    chk("dir_irq", 1, irqs);
    boot(3'h3, 8'h00);
    chk("rst_src", CCM_SRC_CRYSTAL, st.source);
    wrap_up();
  end
endmodule
